// >>> rtl/mie_dev.sv
// interrupting device end: sends requests upstream, takes EOI downstream
// assumes the link interface joins it to a host end
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module mie_dev
   import mie_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic [4:0]  UNIT_ID_I,
   input  wire logic        INT_REQ_I,
   input  wire logic [55:2] INT_INFO_I,
   input  wire logic        PASS_PW_REQ_I,
   input  wire logic        FLUSH_DONE_I,
   input  wire logic        FENCE_REQ_I,
   input  wire logic        CFG_CLR_WAIT_I,
   output logic             INT_BUSY_O,
   output logic             INT_TAKEN_O,
   output logic             WAITING_O,
   output logic             EOI_FWD_O,
   output logic [23:0]      EOI_INFO_O,
   mie_link_if.dev          link
);
   mie_dtx_t    state_reg;
   logic [3:0]  tx_idx_reg;
   logic [7:0]  pkt_reg [0:11];
   logic        ack_req_reg;
   logic [23:0] pend_reg;
   logic        tx_adv;
   logic        tx_ctl;
   logic [7:0]  tx_cad;
   logic        rx_stb;
   logic        rx_ctl;
   logic [7:0]  rx_cad;
   logic        rx_busy_reg;
   logic [2:0]  rx_idx_reg;
   logic [7:0]  rx_buf_reg [0:6];
   logic        accept;
   logic        send_done;
   logic        eoi_hit;
   logic        pass_pw;

   ////////////////////////////////////////////////////////////////
   // eoi info compare with wildcard on low byte
   function automatic logic eoi_match(input logic [23:0] eoi, input logic [23:0] pend);
      eoi_match = (eoi[23:8] == pend[23:8]) && ((eoi[7:0] == 8'h00) || (eoi[7:0] == pend[7:0])); // RULE16
   endfunction

   mie_phy u_phy (
      .clk_i    (CLK_I),
      .rst_i    (SYS_RST_I),
      .tx_ctl_i (tx_ctl),
      .tx_cad_i (tx_cad),
      .tx_adv_o (tx_adv),
      .lk_clk_o (link.up_clk),
      .lk_ctl_o (link.up_ctl),
      .lk_cad_o (link.up_cad),
      .lk_clk_i (link.dn_clk),
      .lk_ctl_i (link.dn_ctl),
      .lk_cad_i (link.dn_cad),
      .rx_stb_o (rx_stb),
      .rx_ctl_o (rx_ctl),
      .rx_cad_o (rx_cad)
   );

   ////////////////////////////////////////////////////////////////
   // request acceptance
   assign INT_BUSY_O = (state_reg != DT_IDLE) | WAITING_O; // RULE7
   assign accept     = INT_REQ_I & ~INT_BUSY_O & (INT_INFO_I[4:2] != TYPE_EOI); // RULE5
   assign pass_pw    = PASS_PW_REQ_I & FLUSH_DONE_I; // RULE11
   assign send_done  = tx_adv & (state_reg == DT_REQ) & (tx_idx_reg == REQ_LAST);

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         INT_TAKEN_O <= 1'b0;
      end else begin
         INT_TAKEN_O <= accept;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         for (int i = 0; i < 12; i++) begin
            pkt_reg[i] <= 8'h00;
         end
         ack_req_reg <= 1'b0;
         pend_reg    <= 24'h000000;
      end else if (accept) begin
         pkt_reg[0]  <= {2'b00, CMD_WRSZ_PB}; // RULE1
         pkt_reg[1]  <= {pass_pw, 2'b00, UNIT_ID_I}; // RULE11
         pkt_reg[2]  <= 8'h00; // RULE2
         pkt_reg[3]  <= {INT_INFO_I[7:2], 2'b00}; // RULE4
         pkt_reg[4]  <= INT_INFO_I[15:8]; // RULE4
         pkt_reg[5]  <= INT_INFO_I[23:16]; // RULE4
         pkt_reg[6]  <= INT_INFO_I[31:24]; // RULE4
         pkt_reg[7]  <= INTR_ADDR_HI; // RULE1
         pkt_reg[8]  <= INT_INFO_I[39:32]; // RULE3
         pkt_reg[9]  <= INT_INFO_I[47:40]; // RULE3
         pkt_reg[10] <= INT_INFO_I[55:48]; // RULE4
         pkt_reg[11] <= 8'h00; // RULE4
         ack_req_reg <= INT_INFO_I[5]; // RULE6
         pend_reg    <= INT_INFO_I[31:8];
      end
   end

   ////////////////////////////////////////////////////////////////
   // transmit sequencing, in order on one posted channel
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         state_reg  <= DT_IDLE;
         tx_idx_reg <= 4'h0;
      end else begin
         case (state_reg)
            DT_IDLE: begin
               if (accept) begin
                  state_reg <= FENCE_REQ_I ? DT_FENCE : DT_REQ; // RULE12
               end
            end
            DT_FENCE: begin
               if (tx_adv) begin
                  tx_idx_reg <= (tx_idx_reg == FENCE_LAST) ? 4'h0 : tx_idx_reg + 4'h1;
                  if (tx_idx_reg == FENCE_LAST) begin
                     state_reg <= DT_REQ; // RULE12
                  end
               end
            end
            DT_REQ: begin
               if (tx_adv) begin
                  tx_idx_reg <= send_done ? 4'h0 : tx_idx_reg + 4'h1;
                  if (send_done) begin
                     state_reg <= DT_IDLE; // RULE10
                  end
               end
            end
            default: begin
               state_reg  <= DT_IDLE;
               tx_idx_reg <= 4'h0;
            end
         endcase
      end
   end

   always_comb begin
      tx_ctl = 1'b1;
      tx_cad = {2'b00, CMD_NOP};
      case (state_reg)
         DT_FENCE: begin
            if (tx_idx_reg == 4'h0) begin
               tx_cad = {2'b00, CMD_FENCE}; // RULE12
            end else if (tx_idx_reg == 4'h1) begin
               tx_cad = {3'b000, UNIT_ID_I};
            end else begin
               tx_cad = 8'h00;
            end
         end
         DT_REQ: begin
            tx_ctl = (tx_idx_reg <= CTL_LAST);
            tx_cad = pkt_reg[tx_idx_reg];
         end
         default: begin
            tx_ctl = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // receive control packets from downstream link
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         rx_busy_reg <= 1'b0;
         rx_idx_reg  <= 3'h0;
         for (int i = 0; i < 7; i++) begin
            rx_buf_reg[i] <= 8'h00;
         end
      end else if (rx_stb & rx_ctl) begin
         if (!rx_busy_reg) begin
            if (rx_cad[5:0] != CMD_NOP) begin
               rx_busy_reg   <= 1'b1;
               rx_idx_reg    <= 3'h1;
               rx_buf_reg[0] <= rx_cad;
            end
         end else if (rx_idx_reg == 3'h7) begin
            rx_busy_reg <= 1'b0;
            rx_idx_reg  <= 3'h0;
         end else begin
            rx_buf_reg[rx_idx_reg] <= rx_cad;
            rx_idx_reg             <= rx_idx_reg + 3'h1;
         end
      end
   end

   assign eoi_hit = rx_stb & rx_ctl & rx_busy_reg & (rx_idx_reg == 3'h7) & (rx_cad == INTR_ADDR_HI)
                    & (rx_buf_reg[0][5:0] == CMD_BCAST) & (rx_buf_reg[3][4:2] == TYPE_EOI);

   ////////////////////////////////////////////////////////////////
   // eoi forward and waiting status
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         EOI_FWD_O  <= 1'b0;
         EOI_INFO_O <= 24'h000000;
      end else begin
         EOI_FWD_O <= eoi_hit; // RULE14
         if (eoi_hit) begin
            EOI_INFO_O <= {rx_buf_reg[6], rx_buf_reg[5], rx_buf_reg[4]}; // RULE14
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         WAITING_O <= 1'b0;
      end else if (send_done & ack_req_reg) begin
         WAITING_O <= 1'b1; // RULE19
      end else if (CFG_CLR_WAIT_I) begin
         WAITING_O <= 1'b0; // RULE17
      end else if (eoi_hit && eoi_match({rx_buf_reg[6], rx_buf_reg[5], rx_buf_reg[4]}, pend_reg)) begin
         WAITING_O <= 1'b0; // RULE19
      end
   end
endmodule

// >>> rtl/mie_host.sv
// host bridge end: receives interrupt requests, broadcasts EOI
// assumes an APB master with 32-bit data on the register side
`timescale 1ns/1ps
module mie_host
   import mie_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic [31:0]      PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   mie_link_if.host         link
);
   logic [23:0] eoi_info_reg;
   logic        eoi_busy_reg;
   logic [3:0]  tx_idx_reg;
   logic [3:0]  rx_idx_reg;
   logic        rx_busy_reg;
   logic [3:0]  rx_last_reg;
   logic [7:0]  rx_buf_reg [0:11];
   logic [55:2] rx_info_reg;
   logic [5:0]  rx_unit_reg;
   logic        rx_valid_reg;
   logic [7:0]  rx_count_reg;
   logic        tx_adv;
   logic        tx_ctl;
   logic [7:0]  tx_cad;
   logic        rx_stb;
   logic        rx_ctl;
   logic [7:0]  rx_cad;
   logic        wr;
   logic        req_done;
   logic        mapped;

   mie_phy u_phy (
      .clk_i    (CLK_I),
      .rst_i    (SYS_RST_I),
      .tx_ctl_i (tx_ctl),
      .tx_cad_i (tx_cad),
      .tx_adv_o (tx_adv),
      .lk_clk_o (link.dn_clk),
      .lk_ctl_o (link.dn_ctl),
      .lk_cad_o (link.dn_cad),
      .lk_clk_i (link.up_clk),
      .lk_ctl_i (link.up_ctl),
      .lk_cad_i (link.up_cad),
      .rx_stb_o (rx_stb),
      .rx_ctl_o (rx_ctl),
      .rx_cad_o (rx_cad)
   );

   ////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   assign PREADY_O  = 1'b1;
   assign mapped    = (PADDR_I == OFS_CTRL) || (PADDR_I == OFS_EOI_INFO) || (PADDR_I == OFS_STATUS)
                      || (PADDR_I == OFS_RX_LO) || (PADDR_I == OFS_RX_HI);
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
   assign wr        = PSEL_I & PENABLE_I & PWRITE_I;

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         PRDATA_O <= 32'h00000000;
      end else if (PSEL_I & ~PENABLE_I) begin
         if (PADDR_I == OFS_CTRL) begin
            PRDATA_O <= {31'h00000000, eoi_busy_reg};
         end else if (PADDR_I == OFS_EOI_INFO) begin
            PRDATA_O <= {eoi_info_reg, 8'h00};
         end else if (PADDR_I == OFS_STATUS) begin
            PRDATA_O <= {16'h0000, rx_count_reg, 6'h00, rx_valid_reg, eoi_busy_reg};
         end else if (PADDR_I == OFS_RX_LO) begin
            PRDATA_O <= {rx_info_reg[31:2], 2'b00};
         end else if (PADDR_I == OFS_RX_HI) begin
            PRDATA_O <= {2'b00, rx_unit_reg, rx_info_reg[55:32]};
         end else begin
            PRDATA_O <= 32'h00000000;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         eoi_info_reg <= EOI_INFO_RST;
      end else if (wr && PADDR_I == OFS_EOI_INFO) begin
         eoi_info_reg <= PWDATA_I[31:8]; // RULE8
      end
   end

   ////////////////////////////////////////////////////////////////
   // eoi broadcast, downstream only
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         eoi_busy_reg <= 1'b0;
         tx_idx_reg   <= 4'h0;
      end else if (!eoi_busy_reg) begin
         eoi_busy_reg <= wr && (PADDR_I == OFS_CTRL) && PWDATA_I[CTRL_SEND_BIT]; // RULE13
      end else if (tx_adv) begin
         tx_idx_reg   <= (tx_idx_reg == CTL_LAST) ? 4'h0 : tx_idx_reg + 4'h1;
         eoi_busy_reg <= (tx_idx_reg != CTL_LAST);
      end
   end

   always_comb begin
      tx_ctl = 1'b1;
      tx_cad = {2'b00, CMD_NOP};
      if (eoi_busy_reg) begin
         case (tx_idx_reg)
            4'h0: tx_cad = {2'b00, CMD_BCAST}; // RULE13
            4'h3: tx_cad = {3'b000, TYPE_EOI, 2'b00}; // RULE15
            4'h4: tx_cad = eoi_info_reg[7:0]; // RULE15
            4'h5: tx_cad = eoi_info_reg[15:8]; // RULE15
            4'h6: tx_cad = eoi_info_reg[23:16]; // RULE15
            4'h7: tx_cad = INTR_ADDR_HI; // RULE13
            default: tx_cad = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // request receive, never stalls the posted channel
   assign req_done = rx_stb & rx_busy_reg & (rx_idx_reg == rx_last_reg) & (rx_buf_reg[0][5:0] == CMD_WRSZ_PB);

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         rx_busy_reg <= 1'b0;
         rx_idx_reg  <= 4'h0;
         rx_last_reg <= 4'h0;
         for (int i = 0; i < 12; i++) begin
            rx_buf_reg[i] <= 8'h00;
         end
      end else if (rx_stb) begin
         if (!rx_busy_reg) begin
            if (rx_ctl && rx_cad[5:0] != CMD_NOP) begin
               rx_busy_reg   <= 1'b1;
               rx_idx_reg    <= 4'h1;
               rx_buf_reg[0] <= rx_cad;
               rx_last_reg   <= (rx_cad[5:0] == CMD_WRSZ_PB) ? REQ_LAST
                                : ((rx_cad[5:0] == CMD_FENCE) ? FENCE_LAST : CTL_LAST);
            end
         end else begin
            rx_buf_reg[rx_idx_reg] <= rx_cad;
            rx_idx_reg             <= (rx_idx_reg == rx_last_reg) ? 4'h0 : rx_idx_reg + 4'h1;
            rx_busy_reg            <= (rx_idx_reg != rx_last_reg); // RULE10
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         rx_info_reg  <= 54'h0;
         rx_unit_reg  <= 6'h00;
         rx_count_reg <= 8'h00;
         rx_valid_reg <= 1'b0;
      end else begin
         if (req_done) begin
            rx_info_reg  <= {rx_buf_reg[10], rx_buf_reg[9], rx_buf_reg[8], rx_buf_reg[6], rx_buf_reg[5],
                             rx_buf_reg[4], rx_buf_reg[3][7:2]};
            rx_unit_reg  <= {rx_buf_reg[1][7], rx_buf_reg[1][4:0]};
            rx_count_reg <= rx_count_reg + 8'h01; // RULE9
            rx_valid_reg <= 1'b1; // RULE9
         end else if (wr && PADDR_I == OFS_STATUS && PWDATA_I[ST_VALID_BIT]) begin
            rx_valid_reg <= 1'b0;
         end
      end
   end
endmodule

// >>> rtl/mie_link_if.sv
// link between device end and host end
// each direction carries its own clock made by its sender
`timescale 1ns/1ps
interface mie_link_if;
   logic       up_clk;
   logic       up_ctl;
   logic [7:0] up_cad;
   logic       dn_clk;
   logic       dn_ctl;
   logic [7:0] dn_cad;
   modport dev  (output up_clk, output up_ctl, output up_cad, input dn_clk, input dn_ctl, input dn_cad);
   modport host (input up_clk, input up_ctl, input up_cad, output dn_clk, output dn_ctl, output dn_cad);
endinterface

// >>> rtl/mie_phy.sv
// one link port: clock divider transmitter and sampled receiver
// assumes incoming link signals are asynchronous to clk_i
`timescale 1ns/1ps
module mie_phy
   import mie_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       tx_ctl_i,
   input  wire logic [7:0] tx_cad_i,
   output logic            tx_adv_o,
   output logic            lk_clk_o,
   output logic            lk_ctl_o,
   output logic [7:0]      lk_cad_o,
   input  wire logic       lk_clk_i,
   input  wire logic       lk_ctl_i,
   input  wire logic [7:0] lk_cad_i,
   output logic            rx_stb_o,
   output logic            rx_ctl_o,
   output logic [7:0]      rx_cad_o
);
   logic [2:0] div_reg;
   logic [9:0] s1_reg;
   logic [9:0] s2_reg;
   logic       clk_d_reg;

   ////////////////////////////////////////////////////////////////
   // transmit: byte changes while link clock is low
   assign tx_adv_o = (div_reg == DIV_LAST);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg  <= 3'h0;
         lk_clk_o <= 1'b0;
         lk_ctl_o <= 1'b1;
         lk_cad_o <= 8'h00;
      end else begin
         div_reg  <= tx_adv_o ? 3'h0 : div_reg + 3'h1;
         lk_clk_o <= (div_reg == DIV_RISE - 3'h1) ? 1'b1 : (tx_adv_o ? 1'b0 : lk_clk_o);
         if (tx_adv_o) begin
            lk_ctl_o <= tx_ctl_i;
            lk_cad_o <= tx_cad_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // receive: two-stage sync then rising edge sample
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg    <= 10'h000;
         s2_reg    <= 10'h000;
         clk_d_reg <= 1'b0;
         rx_stb_o  <= 1'b0;
         rx_ctl_o  <= 1'b0;
         rx_cad_o  <= 8'h00;
      end else begin
         s1_reg    <= {lk_clk_i, lk_ctl_i, lk_cad_i};
         s2_reg    <= s1_reg;
         clk_d_reg <= s2_reg[9];
         rx_stb_o  <= s2_reg[9] & ~clk_d_reg;
         if (s2_reg[9] & ~clk_d_reg) begin
            rx_ctl_o <= s2_reg[8];
            rx_cad_o <= s2_reg[7:0];
         end
      end
   end
endmodule

// >>> rtl/mie_pkg.sv
// constants shared by both ends of the message interrupt link
// assumes one 10 MHz system clock at each end
// Contract
// [RULE1] requests go posted byte sized write
// [RULE2] request count field is always zero
// [RULE3] request data word carries info, not masks
// [RULE4] info bits packed into bit-times and data
// [RULE5] type in info 4:2, 111 only EOI
// [RULE6] info bit 5 asks for EOI
// [RULE7] no new request while waiting status set
// [RULE8] host returns info 31:8 in EOI
// [RULE9] host accepts many requests without stalling
// [RULE10] pass bit clear pushes earlier posted writes
// [RULE11] pass bit set only after flush done
// [RULE12] optional fence ahead of the request
// [RULE13] EOI broadcast downstream into interrupt range
// [RULE14] device accepts, clears matching, forwards EOI
// [RULE15] EOI type 111, info 31:8 duplicated
// [RULE16] zero info 15:8 in EOI matches any
// [RULE17] config clear of waiting ends service
// [RULE18] software sets only host-valid requests
// [RULE19] waiting set on acked send, cleared by EOI
package mie_pkg;
   localparam int         CLK_PERIOD_NS = 100;
   localparam int         LINK_BIT_NS   = 800;
   localparam int         LINK_DIV      = (LINK_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] DIV_LAST      = 3'(LINK_DIV - 1);
   localparam logic [2:0] DIV_RISE      = 3'(LINK_DIV / 2);

   localparam logic [5:0] CMD_NOP       = 6'h00;
   localparam logic [5:0] CMD_WRSZ_PB   = 6'h2C;
   localparam logic [5:0] CMD_BCAST     = 6'h3A;
   localparam logic [5:0] CMD_FENCE     = 6'h3C;
   localparam logic [7:0] INTR_ADDR_HI  = 8'hFD;
   localparam logic [2:0] TYPE_EOI      = 3'h7;
   localparam logic [3:0] REQ_LAST      = 4'hB;
   localparam logic [3:0] CTL_LAST      = 4'h7;
   localparam logic [3:0] FENCE_LAST    = 4'h3;

   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_EOI_INFO  = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h08;
   localparam logic [7:0] OFS_RX_LO     = 8'h0C;
   localparam logic [7:0] OFS_RX_HI     = 8'h10;
   localparam int         CTRL_SEND_BIT = 0;
   localparam int         ST_BUSY_BIT   = 0;
   localparam int         ST_VALID_BIT  = 1;
   localparam int         RXHI_PASS_BIT = 29;
   localparam logic [23:0] EOI_INFO_RST = 24'h000000;

   typedef enum logic [1:0] {
      DT_IDLE  = 2'b00,
      DT_FENCE = 2'b01,
      DT_REQ   = 2'b11
   } mie_dtx_t;
endpackage

// >>> verification/message_interrupt_request_eoi_tb_top.sv
// bench: device end and host end joined by the link interface
// assumes the host register map and zero wait apb timing
`timescale 1ns/1ps
module message_interrupt_request_eoi_tb_top
   import mie_pkg::*;
();
   localparam logic [55:0] IA  = 56'h123456_765432_24;
   localparam logic [55:0] IB  = 56'h0A0B0C_112233_04;
   localparam logic [55:0] I7  = 56'h010203_445566_1C;
   localparam logic [4:0]  UID = 5'h0B;
   logic        clk, rst, req, ppw, fld, fen, cfg;
   logic [55:2] info;
   logic        busy, taken, waiting, fwd, psel, pen, pwr, prdy, perr, perr_s;
   logic [23:0] einfo;
   logic [7:0]  paddr;
   logic [31:0] pwd, prd;
   int          bad_count, tests_run;
   ////////////////////////////////////////////////////////////////////////
   mie_link_if u_mie_link_if ();
   mie_dev u_mie_dev (.CLK_I(clk), .SYS_RST_I(rst), .UNIT_ID_I(UID), .INT_REQ_I(req),
      .INT_INFO_I(info), .PASS_PW_REQ_I(ppw), .FLUSH_DONE_I(fld), .FENCE_REQ_I(fen),
      .CFG_CLR_WAIT_I(cfg), .INT_BUSY_O(busy), .INT_TAKEN_O(taken), .WAITING_O(waiting),
      .EOI_FWD_O(fwd), .EOI_INFO_O(einfo), .link(u_mie_link_if));
   mie_host u_mie_host (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .link(u_mie_link_if));
   mie_chk u_mie_chk (.CLK_I(clk), .SYS_RST_I(rst), .up_clk(u_mie_link_if.up_clk),
      .up_ctl(u_mie_link_if.up_ctl), .up_cad(u_mie_link_if.up_cad), .dn_clk(u_mie_link_if.dn_clk),
      .dn_ctl(u_mie_link_if.dn_ctl), .dn_cad(u_mie_link_if.dn_cad));
   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      psel  <= 1'b1;
      pwr   <= w;
      paddr <= a;
      pwd   <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      q = prd;
      perr_s = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rq(input logic [55:0] v, input logic f, input logic p, input logic l, output logic t);
      info <= v[55:2];
      fen  <= f;
      ppw  <= p;
      fld  <= l;
      req  <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      #1;
      t = taken;
      @(posedge clk);
   endtask
   task automatic wait_rx();
      logic [31:0] q;
      int          n;
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0, q);
         n++;
      end while (q[ST_VALID_BIT] !== 1'b1 && n < 200);
      chk("request received", 1, q[ST_VALID_BIT]);
      apb(1'b1, OFS_STATUS, 32'h2, q);
   endtask
   task automatic eoi(input logic [23:0] x, output logic f);
      logic [31:0] q;
      int          n;
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0, q);
         n++;
      end while (q[ST_BUSY_BIT] !== 1'b0 && n < 100);
      apb(1'b1, OFS_EOI_INFO, {x, 8'h00}, q);
      apb(1'b1, OFS_CTRL, 32'h1, q);
      n = 0;
      while (fwd !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      f = fwd;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_ack();
      logic        t;
      logic        seen;
      logic [31:0] q;
      int          n;
      rq(IA, 1'b1, 1'b1, 1'b1, t);
      chk("taken", 1, t);
      n = 0;
      seen = 1'b0;
      while (!seen && n < 16) begin
         @(posedge clk);
         seen = u_mie_link_if.up_ctl && (u_mie_link_if.up_cad == {2'b00, CMD_FENCE});
         n++;
      end
      chk("fence sent", 1, seen);
      wait_rx();
      chk("waiting set", 1, waiting);
      apb(1'b0, OFS_RX_LO, 32'h0, q);
      chk("rx lo", {IA[31:2], 2'b00}, q);
      apb(1'b0, OFS_RX_HI, 32'h0, q);
      chk("rx hi", {2'b00, 1'b1, UID, IA[55:32]}, q);
      rq(IB, 1'b0, 1'b0, 1'b0, t);
      chk("refused busy", 0, t);
      chk("busy held", 1, busy);
      eoi(IA[31:8], t);
      chk("eoi fwd", 1, t);
      chk("eoi info", IA[31:8], einfo);
      chk("waiting clear", 0, waiting);
      apb(1'b0, OFS_EOI_INFO, 32'h0, q);
      chk("eoi info reg", {IA[31:8], 8'h00}, q);
      $display("t_ack done");
   endtask
   task automatic t_wild();
      logic        t;
      logic [31:0] q;
      rq(IA, 1'b0, 1'b1, 1'b0, t);
      wait_rx();
      apb(1'b0, OFS_RX_HI, 32'h0, q);
      chk("pass clear", 0, q[RXHI_PASS_BIT]);
      eoi({IA[31:16] ^ 16'h0101, IA[15:8]}, t);
      chk("other fwd", 1, t);
      chk("kept waiting", 1, waiting);
      eoi({IA[31:16], 8'h00}, t);
      chk("wild clear", 0, waiting);
      $display("t_wild done");
   endtask
   task automatic t_cfg();
      logic        t;
      logic [31:0] q;
      rq(IA, 1'b0, 1'b0, 1'b0, t);
      wait_rx();
      chk("ack wait", 1, waiting);
      cfg <= 1'b1;
      @(posedge clk);
      cfg <= 1'b0;
      @(posedge clk);
      chk("cfg clear", 0, waiting);
      chk("busy free", 0, busy);
      rq(I7, 1'b0, 1'b0, 1'b0, t);
      chk("type7 refused", 0, t);
      rq(IB, 1'b0, 1'b0, 1'b0, t);
      chk("after cfg", 1, t);
      wait_rx();
      chk("no ack", 0, waiting);
      apb(1'b0, OFS_STATUS, 32'h0, q);
      chk("count", 8'h04, q[15:8]);
      apb(1'b0, 8'h40, 32'h0, q);
      chk("unmapped err", 1, perr_s);
      chk("unmapped rd", 0, q);
      $display("t_cfg done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      {req, ppw, fld, fen, cfg, psel, pen, pwr} = '0;
      info = '0;
      paddr = '0;
      pwd = '0;
      bad_count = 0;
      tests_run = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_ack();
      t_wild();
      t_cfg();
      report_and_stop();
   end
   initial begin
      #3000000;
      bad_count++;
      report_and_stop();
   end
endmodule

// >>> verification/mie_chk.sv
// wire checks on both directions of the message interrupt link
// assumes both ends run from one system clock and share its reset
`timescale 1ns/1ps
module mie_chk
   import mie_pkg::*;
(
   input  wire logic       CLK_I,
   input  wire logic       SYS_RST_I,
   input  wire logic       up_clk,
   input  wire logic       up_ctl,
   input  wire logic [7:0] up_cad,
   input  wire logic       dn_clk,
   input  wire logic       dn_ctl,
   input  wire logic [7:0] dn_cad
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SYS_RST_I);
   ////////////////////////////////////////////////////////////////////////
   // bit-time framing
   up_stand_a: assert property ($fell(up_clk) |=> $stable(up_cad)[*7])
      else $error("upstream byte changed inside a bit-time");
   dn_stand_a: assert property ($fell(dn_clk) |=> $stable(dn_cad)[*7])
      else $error("downstream byte changed inside a bit-time");
   up_clk_high_a: assert property ($rose(up_clk) |-> up_clk[*4] ##1 !up_clk)
      else $error("upstream clock high phase not four cycles");
   ////////////////////////////////////////////////////////////////////////
   // request packet layout
   req_frame_a: assert property ($fell(up_clk) && up_ctl && up_cad == CMD_WRSZ_PB |->
      ##56 up_ctl && up_cad == INTR_ADDR_HI ##8 !up_ctl ##24 !up_ctl && up_cad == 8'h00)
      else $error("request packet framing wrong");
   req_count_a: assert property ($fell(up_clk) && up_ctl && up_cad == CMD_WRSZ_PB |->
      ##16 up_cad == 8'h00 ##8 up_cad[1:0] == 2'b00)
      else $error("request count field not zero");
   req_type_a: assert property ($fell(up_clk) && up_ctl && up_cad == CMD_WRSZ_PB |->
      ##24 up_cad[4:2] != TYPE_EOI)
      else $error("request carries end type");
   fence_frame_a: assert property ($fell(up_clk) && up_ctl && up_cad == CMD_FENCE |->
      ##8 up_cad[7:5] == 3'b000 ##8 up_cad == 8'h00 ##8 up_cad == 8'h00 ##8 up_cad == CMD_WRSZ_PB)
      else $error("fence not followed by request");
   ////////////////////////////////////////////////////////////////////////
   // end of interrupt broadcast
   eoi_frame_a: assert property ($fell(dn_clk) && dn_ctl && dn_cad == CMD_BCAST |->
      ##24 dn_cad == {3'b000, TYPE_EOI, 2'b00} ##32 dn_ctl && dn_cad == INTR_ADDR_HI)
      else $error("end packet layout wrong");
   eoi_down_a: assert property ($fell(up_clk) && up_ctl |-> up_cad != CMD_BCAST)
      else $error("broadcast seen upstream");
endmodule
